/* hw/bvip_top.sv */
// Master and slave vectored interrupt controllers behind a port window
`default_nettype none
module bvip_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [3:0] address_switch_bank,
  input wire logic [1:0] ack_cycle_setting,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic int_ack,
  input wire logic [7:0] vi_lines,
  input wire logic timer_output_two,
  input wire logic timer_output_three,
  input wire logic timer_output_four,
  input wire logic receive_ready_flag,
  input wire logic transmit_ready_flag,
  input wire logic par_in_ready,
  input wire logic par_out_ready,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic int_req,
  output logic [2:0] cascade_sel,
  output logic cascade_oe,
  output logic status_oe
);
  // ===========================================
  // State
  typedef struct packed {
    logic [7:0] in_s1;
    logic [7:0] in_s2;
    logic [6:0] slv_s1;
    logic [6:0] slv_s2;
    logic ack_s1;
    logic ack_s2;
    logic ack_d;
    logic [7:0] m_ctl;
    logic [7:0] m_port_window_origin;
    logic [7:0] m_mask;
    logic [7:0] s_ctl;
    logic [7:0] s_port_window_origin;
    logic [7:0] s_mask;
    bvip_pkg::bvip_state_t st;
    logic from_slave;
    logic [2:0] lvl;
    logic [7:0] dout;
    logic doe;
    logic irq;
    logic [2:0] csel;
    logic coe;
    logic soe;
  } bvip_regs_t;

  bvip_regs_t r_reg, r_next;
  logic [7:0] m_req, s_req;
  logic [2:0] m_lvl, s_lvl;
  logic m_any, s_any, hit, rise, three;
  logic [7:0] cur_ctl, cur_port_window_origin;
  logic [15:0] vaddr;

  // ===========================================
  // Overview of the acknowledge path
  // Every pin-side request input (bus lines, on-board ready flags) and the acknowledge
  // strobe pass two flip-flops before any decision reads them. That costs
  // latency, but the host runs its own timing and a metastable request could
  // otherwise split the priority resolver and the vector mux across levels.
  // The acknowledge strobe is edge-detected after the synchroniser. The
  // delayed copy resets low, matching the idle level of the strobe, so no
  // false pulse is seen straight after reset.
  // The first pulse latches the winning level and the controller that owns it.
  // Everything later in the sequence (vector byte, cascade code, drive enable)
  // comes from that latched state. A request that changes mid-sequence
  // therefore cannot alter the bytes of the cycle already under way.
  // When the winning master input has cascade enabled, an external slave
  // answers. The master then keeps its data drive off and only presents the
  // cascade code. The on-board slave sits on master input 1 and is never
  // cascaded onto the bus.
  // With the cycle setting left open, neither the address nor the status
  // drive is taken. Cascading over the bus is impossible in that case, so
  // the master always supplies the vector itself.
  // Limitation: no in-service tracking and no end-of-interrupt handling.
  // A request stays pending until its source drops.
  // Masks are held clear, so every level is always enabled.
  // The mode bit of the control byte is ignored: the board setting alone
  // decides between the two-byte and the three-byte cycle.
  localparam int BVIP_SLAVE_INPUT_C = bvip_pkg::BVIP_SLAVE_INPUT;

  // Priority: lowest index wins, as in fully nested default
  function automatic logic [2:0] bvip_prio(input logic [7:0] v);
    logic [2:0] p;
    p = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        p = 3'(i);
      end
    end
    return p;
  endfunction : bvip_prio

  // Request mapping after synchronisers
  always_comb begin
    s_req = {r_reg.slv_s2[6], r_reg.slv_s2[5], r_reg.slv_s2[4], r_reg.slv_s2[3],
             r_reg.in_s2[1], r_reg.slv_s2[2], r_reg.slv_s2[1],
             r_reg.slv_s2[0]} & ~r_reg.s_mask;
    s_any = |s_req;
    s_lvl = bvip_prio(s_req);
    m_req = {r_reg.in_s2[7:2], s_any, r_reg.in_s2[0]} & ~r_reg.m_mask;
    m_any = |m_req;
    m_lvl = bvip_prio(m_req);
  end

  // Window decode: unused offsets fall through untouched
  assign hit = (io_addr[7:4] == address_switch_bank) && io_wr;
  assign rise = r_reg.ack_s2 && !r_reg.ack_d;
  assign three = (ack_cycle_setting == bvip_pkg::BVIP_CYC_THREE);
  assign cur_ctl = r_reg.from_slave ? r_reg.s_ctl : r_reg.m_ctl;
  assign cur_port_window_origin = r_reg.from_slave ? r_reg.s_port_window_origin : r_reg.m_port_window_origin;

  // Vector address with interval fill
  always_comb begin
    if (cur_ctl[bvip_pkg::BVIP_CTL_IVL4_BIT]) begin
      vaddr = {cur_port_window_origin, cur_port_window_origin[7:5], r_reg.lvl, 2'h0};
    end else begin
      vaddr = {cur_port_window_origin, cur_port_window_origin[7:6], r_reg.lvl, 3'h0};
    end
  end

  // Next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.in_s1 = vi_lines;
    r_next.in_s2 = r_reg.in_s1;
    r_next.slv_s1 = {timer_output_four, par_out_ready, transmit_ready_flag,
                     timer_output_three, par_in_ready, receive_ready_flag,
                     timer_output_two};
    r_next.slv_s2 = r_reg.slv_s1;
    r_next.ack_s1 = int_ack;
    r_next.ack_s2 = r_reg.ack_s1;
    r_next.ack_d = r_reg.ack_s2;
    r_next.irq = m_any;
    // Register writes; odd offset is register_select_line high
    if (hit) begin
      case (io_addr[3:0])
        bvip_pkg::BVIP_OFS_MASTER_EVEN: r_next.m_ctl = io_wdata;
        bvip_pkg::BVIP_OFS_MASTER_ODD: r_next.m_port_window_origin = io_wdata;
        bvip_pkg::BVIP_OFS_SLAVE_EVEN: r_next.s_ctl = io_wdata;
        bvip_pkg::BVIP_OFS_SLAVE_ODD: r_next.s_port_window_origin = io_wdata;
        default: r_next.m_mask = r_reg.m_mask;
      endcase
    end
    // Mask writes share the control byte high nibble is not used; keep masks clear
    r_next.m_mask = 8'h00;
    r_next.s_mask = 8'h00;
    case (r_reg.st)
      bvip_pkg::BVIP_ST_IDLE: begin
        r_next.doe = 1'b0;
        r_next.coe = 1'b0;
        r_next.soe = 1'b0;
        if (rise && m_any) begin
          // First pulse resolves priority and cascade
          r_next.from_slave = (m_lvl == 3'(BVIP_SLAVE_INPUT_C));
          r_next.lvl = (m_lvl == 3'(BVIP_SLAVE_INPUT_C)) ? s_lvl : m_lvl;
          r_next.csel = m_lvl;
          // Bus cascade only when master input is cascade-enabled and not slave
          r_next.coe = (ack_cycle_setting != bvip_pkg::BVIP_CYC_NONE) &&
                       r_reg.m_ctl[bvip_pkg::BVIP_CTL_CASC_BIT] &&
                       (m_lvl != 3'(BVIP_SLAVE_INPUT_C));
          r_next.soe = (ack_cycle_setting != bvip_pkg::BVIP_CYC_NONE);
          r_next.dout = bvip_pkg::BVIP_CALL_OPCODE;
          r_next.doe = three && !r_next.coe;
          r_next.st = bvip_pkg::BVIP_ST_P1;
        end
      end
      bvip_pkg::BVIP_ST_P1: begin
        if (rise) begin
          if (three) begin
            r_next.dout = vaddr[7:0];
          end else begin
            r_next.dout = {cur_port_window_origin[7:3], r_reg.lvl};
          end
          r_next.doe = !r_reg.coe;
          r_next.st = three ? bvip_pkg::BVIP_ST_P2 : bvip_pkg::BVIP_ST_P3;
        end
      end
      bvip_pkg::BVIP_ST_P2: begin
        if (rise) begin
          r_next.dout = vaddr[15:8];
          r_next.st = bvip_pkg::BVIP_ST_P3;
        end
      end
      bvip_pkg::BVIP_ST_P3: begin
        if (!r_reg.ack_s2) begin
          r_next.doe = 1'b0;
          r_next.coe = 1'b0;
          r_next.soe = 1'b0;
          r_next.st = bvip_pkg::BVIP_ST_IDLE;
        end
      end
      default: r_next.st = bvip_pkg::BVIP_ST_IDLE;
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.st <= bvip_pkg::BVIP_ST_IDLE;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign data_out = r_reg.dout;
  assign data_oe = r_reg.doe;
  assign int_req = r_reg.irq;
  assign cascade_sel = r_reg.csel;
  assign cascade_oe = r_reg.coe;
  assign status_oe = r_reg.soe;
endmodule : bvip_top
`default_nettype wire

/* hw/bvip_pkg.sv */
// Package of constants and types for the board vectored interrupt pair
// Operation
// - Respond only when address bits 7-4 match switches
// - Offsets 0,1 master; 2,3 slave; odd selects high
// - Offsets 8-11, 13/15 output left undecoded
// - Master input 1 fed by slave interrupt output
// - Master inputs 0,2-7 from bus lines; line 1 slave
// - Master bus inputs cascadable; slave bus input not
// - Slave inputs: timers, serial, parallel, bus line 1
// - Call mode: first pulse drives opcode CD hex
// - Call mode: second low byte, third high byte
// - Call interval 4 or 8 fills low address bits
// - Vector mode: first pulse resolves, no data drive
// - Vector mode: second pulse drives type byte
// - Board setting selects two-byte or three-byte cycle
// - Setting unconnected: no address/status drive, no cascade
`default_nettype none
package bvip_pkg;
  // ===========================================
  // Port window
  localparam logic [3:0] BVIP_OFS_MASTER_EVEN = 4'h0;
  localparam logic [3:0] BVIP_OFS_MASTER_ODD = 4'h1;
  localparam logic [3:0] BVIP_OFS_SLAVE_EVEN = 4'h2;
  localparam logic [3:0] BVIP_OFS_SLAVE_ODD = 4'h3;
  localparam logic [7:0] BVIP_CALL_OPCODE = 8'hCD;
  localparam int BVIP_SLAVE_INPUT = 1;
  localparam int BVIP_SLAVE_BUS_LEVEL = 3;
  // ===========================================
  // Control word fields (odd offset: port_window_origin byte; even offset: control byte)
  localparam int BVIP_CTL_CALL_BIT = 0;
  localparam int BVIP_CTL_IVL4_BIT = 1;
  localparam int BVIP_CTL_CASC_BIT = 2;
  // Acknowledge cycle setting
  typedef enum logic [1:0] {
    BVIP_CYC_NONE = 2'h0,
    BVIP_CYC_TWO = 2'h1,
    BVIP_CYC_THREE = 2'h2
  } bvip_cycle_t;
  // Acknowledge sequencer states
  typedef enum logic [3:0] {
    BVIP_ST_IDLE = 4'h1,
    BVIP_ST_P1 = 4'h2,
    BVIP_ST_P2 = 4'h4,
    BVIP_ST_P3 = 4'h8
  } bvip_state_t;
endpackage : bvip_pkg
`default_nettype wire

/* test/bvip_props.sv */
// Checker for acknowledge drive and request behaviour at the top ports
`default_nettype none
module bvip_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [1:0] ack_cycle_setting,
  input wire logic int_ack,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic int_req,
  input wire logic cascade_oe,
  input wire logic status_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========
  // Acknowledge steps; bus turn-on only happens inside a pulse
  sequence drive_start_s; $rose(data_oe); endsequence
  sequence ack_idle_s; !int_ack [*8]; endsequence
  call_opcode_a: assert property (
    drive_start_s |-> ack_cycle_setting != 2'h2 || data_out == 8'hCD) else $error("opcode");
  oe_in_ack_a: assert property (drive_start_s |-> int_ack) else $error("stray drive");
  ack_release_a: assert property (ack_idle_s |-> !data_oe) else $error("bus held");
  oe_hold_a: assert property (data_oe && int_ack |=> data_oe) else $error("oe drop");
  none_quiet_a: assert property (
    ack_cycle_setting == 2'h0 |-> !cascade_oe && !status_oe) else $error("bus taken");
  casc_ack_a: assert property ($rose(cascade_oe) |-> int_ack) else $error("cascade");
  stat_ack_a: assert property ($rose(status_oe) |-> int_ack) else $error("status");
  reset_quiet_a: assert property (
    $rose(resetn) |-> !data_oe && !int_req) else $error("reset state");
endmodule : bvip_props
bind bvip_top bvip_props props_u (.clk_sys, .resetn, .ack_cycle_setting, .int_ack,
  .data_out, .data_oe, .int_req, .cascade_oe, .status_oe);
`default_nettype wire

/* test/bvip_host.sv */
// Host model that runs acknowledge pulses and samples the data bus
`default_nettype none
module bvip_host (
  input wire logic clk_sys,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic int_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] seen [3];
  initial int_ack = 1'b0;
  // Pulses 8 high and 6 low; sampled late so the 2-flop sync and output register have landed
  task automatic ack(input int n);
    for (int i = 0; i < n; i++) begin
      int_ack <= 1'b1;
      repeat (8) @(posedge clk_sys);
      seen[i] = {data_oe, data_out};
      int_ack <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask : ack
endmodule : bvip_host
`default_nettype wire

/* test/bvip_bench.sv */
// Self-checking bench for the vectored interrupt pair
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module bvip_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] ack_cycle_setting = 2'h0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic [7:0] vi_lines = 8'h00;
  logic [6:0] src = 7'h00;
  logic [7:0] data_out;
  logic data_oe;
  logic int_req;
  logic int_ack;
  logic [2:0] cascade_sel;
  logic cascade_oe;
  logic status_oe;
  logic [2:0] csel_seen = 3'h7;
  int casc_cnt = 0;
  int stat_cnt = 0;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 clk_sys = ~clk_sys;
  // Switches all closed: window origin at F0
  bvip_top dut_u (.clk_sys, .resetn, .clk_en(1'h1), .address_switch_bank(4'hF),
    .ack_cycle_setting, .io_addr, .io_wr, .io_rd(1'h0), .io_wdata, .int_ack, .vi_lines,
    .timer_output_two(src[0]), .timer_output_three(src[1]), .timer_output_four(src[2]),
    .receive_ready_flag(src[3]), .transmit_ready_flag(src[4]), .par_in_ready(src[5]),
    .par_out_ready(src[6]), .data_out, .data_oe, .int_req, .cascade_sel, .cascade_oe,
    .status_oe);
  bvip_host host_u (.clk_sys, .data_out, .data_oe, .int_ack);
  // Count cycles of cascade and status drive; keep the last cascade code
  always @(posedge clk_sys) begin
    if (cascade_oe === 1'b1) begin
      casc_cnt++;
      csel_seen = cascade_sel;
    end
    if (status_oe === 1'b1) stat_cnt++;
  end
  // One-cycle write, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  // Bounded wait for the request line
  task automatic wait_req;
    for (int k = 0; k < 20 && int_req !== 1'b1; k++) @(posedge clk_sys);
    `CHK("int_req", 1'b1, int_req)
  endtask : wait_req
  // Drop all requests and see the request line fall; avoids a stale request
  task automatic quiet;
    vi_lines <= 8'h00;
    src <= 7'h00;
    repeat (6) @(posedge clk_sys);
    `CHK("int_req_low", 1'b0, int_req)
  endtask : quiet
  // Three-byte cycle, interval 4, with decoys outside the window and at an unused window offset
  task automatic t_call;
    ack_cycle_setting <= 2'h2;
    wr(8'hF0, 8'h02);
    wr(8'hF1, 8'hE0);
    wr(8'h71, 8'h00);
    wr(8'hF9, 8'h00);
    vi_lines <= 8'h08;
    wait_req();
    host_u.ack(3);
    `CHK("opcode", 9'h1CD, host_u.seen[0])
    `CHK("low", 9'h1EC, host_u.seen[1])
    `CHK("high", 9'h1E0, host_u.seen[2])
    quiet();
    $display("call test done");
  endtask : t_call
  // Two-byte cycle: quiet first pulse, then the type byte
  task automatic t_vector;
    ack_cycle_setting <= 2'h1;
    wr(8'hF1, 8'hA8);
    vi_lines <= 8'h04;
    wait_req();
    host_u.ack(2);
    `CHK("first_oe", 1'b0, host_u.seen[0][8])
    `CHK("vector", 9'h1AA, host_u.seen[1])
    quiet();
    $display("vector test done");
  endtask : t_vector
  // Bus line 1 reaches the on-board slave through master input 1
  task automatic t_slave;
    int c0;
    wr(8'hF0, 8'h04);
    c0 = casc_cnt;
    wr(8'hF3, 8'h50);
    vi_lines <= 8'h02;
    wait_req();
    host_u.ack(2);
    `CHK("slave_vec", 9'h153, host_u.seen[1])
    `CHK("slave_nocasc", 1'b1, casc_cnt == c0)
    quiet();
    src <= 7'h02;
    wait_req();
    host_u.ack(2);
    `CHK("slave_timer3", 9'h154, host_u.seen[1])
    quiet();
    $display("slave test done");
  endtask : t_slave
  // Cascaded master input: external slave answers, then the same with no setting
  task automatic t_cascade;
    int c0;
    int s0;
    ack_cycle_setting <= 2'h1;
    vi_lines <= 8'h04;
    wait_req();
    c0 = casc_cnt;
    s0 = stat_cnt;
    host_u.ack(2);
    `CHK("casc_oe1", 1'b0, host_u.seen[0][8])
    `CHK("casc_oe2", 1'b0, host_u.seen[1][8])
    `CHK("casc_drive", 1'b1, casc_cnt > c0)
    `CHK("casc_sel", 3'h2, csel_seen)
    `CHK("stat_drive", 1'b1, stat_cnt > s0)
    quiet();
    ack_cycle_setting <= 2'h0;
    vi_lines <= 8'h04;
    wait_req();
    c0 = casc_cnt;
    s0 = stat_cnt;
    host_u.ack(2);
    `CHK("none_vec", 9'h1AA, host_u.seen[1])
    `CHK("none_casc", 1'b1, casc_cnt == c0)
    `CHK("none_stat", 1'b1, stat_cnt == s0)
    quiet();
    $display("cascade test done");
  endtask : t_cascade
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // Scenarios need a few hundred cycles; 3000 is a generous ceiling
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  // Reset for 4 cycles, then the scenarios
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_call();
    t_vector();
    t_slave();
    t_cascade();
    final_report();
  end
endmodule : bvip_bench
`default_nettype wire
